// [verilog/daq_timing_pkg.sv]
// Purpose: shared constants for the timing signal router
// Assumes: 32-bit register bus, byte addresses in the low 8 bits
// Notes:   source codes of 2'h3 are reserved and fall back to internal, except trigger sources where 2'h3 selects the bus
package daq_timing_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] clock_src_offset   = 8'h00;
    localparam logic [7:0] trigger_src_offset = 8'h04;
    localparam logic [7:0] strobe_src_offset  = 8'h08;
    localparam logic [7:0] sync_master_offset = 8'h0c;
    localparam logic [7:0] soft_trig_offset   = 8'h10;
    localparam logic [7:0] status_offset      = 8'h14;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int conv_trig_src_lsb  = 0;
    localparam int out_trig_src_lsb   = 2;
    localparam int conv_trig_fall_bit = 4;
    localparam int out_trig_fall_bit  = 5;
    localparam int scan_src_lsb       = 0;
    localparam int strobe_src_lsb     = 2;
    localparam int update_src_lsb     = 4;
    localparam int soft_conv_bit      = 0;
    localparam int soft_out_bit       = 1;
    localparam int refused_bit        = 2;

    // ************************************************************
    // source codes, 2'h0 is the internal source everywhere
    // ************************************************************
    localparam logic [1:0] src_internal = 2'h0;
    localparam logic [1:0] src_external = 2'h1;
    localparam logic [1:0] src_analog   = 2'h2;
    localparam logic [1:0] src_aux      = 2'h1;
    localparam logic [1:0] src_bus      = 2'h2;
    localparam logic [1:0] trig_src_bus = 2'h3;
    localparam logic [1:0] src_reserved = 2'h3;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [1:0] reset_src    = 2'h0;
    localparam logic [5:0] reset_master = 6'h00;

    // ************************************************************
    // synchronised input positions and bus line order
    // ************************************************************
    localparam int in_int_clk   = 0;
    localparam int in_ext_clk   = 1;
    localparam int in_aux_zero  = 2;
    localparam int in_aux_one   = 3;
    localparam int in_conv_ext  = 4;
    localparam int in_out_ext   = 5;
    localparam int in_bus_base  = 6;
    localparam int num_inputs   = 12;
    localparam int bus_clock    = 0;
    localparam int bus_conv_trg = 1;
    localparam int bus_scan     = 2;
    localparam int bus_strobe   = 3;
    localparam int bus_out_trg  = 4;
    localparam int bus_update   = 5;

    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

endpackage : daq_timing_pkg

// [verilog/edge_sense_if.sv]
// Purpose: carries one raw input and its synchronised level and edges
// Assumes: single clock domain on the sensing side
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/10ps
interface edge_sense_if;
    logic raw;
    logic level;
    logic rise;
    logic fall;
    modport sense (input raw, output level, output rise, output fall);
    modport user  (output raw, input level, input rise, input fall);
endinterface : edge_sense_if

// [verilog/edge_sense.sv]
// Purpose: two-stage synchroniser followed by edge detection
// Assumes: raw input is asynchronous to aclk
// Notes:   edges come one to two cycles after the pin moves
`timescale 1ns/10ps
module edge_sense (
    input wire logic      aclk,
    input wire logic      aresetn,
    edge_sense_if.sense   port
);
    logic meta;
    logic stable;
    logic prior;

    // first stage feeds only the second, nothing else looks at it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            prior  <= 1'b0;
        end else begin
            meta   <= port.raw;
            stable <= meta;
            prior  <= stable;
        end
    end

    assign port.level = stable;
    assign port.rise  = stable & ~prior;
    assign port.fall  = ~stable & prior;

endmodule : edge_sense

// [verilog/daq_timing_signal_router.sv]
// Purpose: picks the source of every acquisition timing signal
// Assumes: aclk 100 MHz, count clocks arrive as levels and are sampled
// Notes:   register access over AXI4-Lite, one transfer of each kind at a time
`timescale 1ns/10ps
module daq_timing_signal_router (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // register bus
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // internal generators, same clock
    input  wire logic        scan_interval_tick,
    input  wire logic        conversion_tick,
    input  wire logic        update_tick,
    input  wire logic        analog_trigger,
    // pins from outside the clock domain
    input  wire logic        internal_count_clock_in,
    input  wire logic        external_count_clock_in,
    input  wire logic        aux_input_zero,
    input  wire logic        aux_input_one,
    input  wire logic        converter_ext_trigger_in,
    input  wire logic        output_ext_trigger_in,
    input  wire logic [5:0]  card_sync_bus_in,
    output logic [5:0]       card_sync_bus_out,
    output logic [5:0]       card_sync_bus_oe_n,
    // routed timing signals
    output logic             count_clock_tick,
    output logic             converter_trigger,
    output logic             output_path_trigger,
    output logic             scan_begin,
    output logic             conversion_strobe,
    output logic             output_update_strobe
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic pick(input logic [1:0] sel, input logic a, b, c, d);
        return sel[1] ? (sel[0] ? d : c) : (sel[0] ? b : a);
    endfunction : pick

    // reserved codes fall back to the internal source
    function automatic logic [1:0] legal(input logic [1:0] f);
        return (f == daq_timing_pkg::src_reserved) ? daq_timing_pkg::src_internal : f;
    endfunction : legal
    // unmapped offsets answer with an error and change nothing
    function automatic logic reg_mapped(input logic [7:0] a);
        return (a == daq_timing_pkg::clock_src_offset) | (a == daq_timing_pkg::trigger_src_offset)
             | (a == daq_timing_pkg::strobe_src_offset) | (a == daq_timing_pkg::sync_master_offset)
             | (a == daq_timing_pkg::soft_trig_offset) | (a == daq_timing_pkg::status_offset);
    endfunction : reg_mapped

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [11:0] raw_in;
    logic [11:0] lvl;
    logic [11:0] rise;
    logic [11:0] fall;

    assign raw_in = {card_sync_bus_in, output_ext_trigger_in, converter_ext_trigger_in,
                     aux_input_one, aux_input_zero, external_count_clock_in,
                     internal_count_clock_in};

    for (genvar i = 0; i < daq_timing_pkg::num_inputs; i++) begin : g_in
        edge_sense_if e ();
        assign e.raw = raw_in[i];
        edge_sense u_sense (
            .aclk    (aclk),
            .aresetn (aresetn),
            .port    (e)
        );
        assign lvl[i]  = e.level;
        assign rise[i] = e.rise;
        assign fall[i] = e.fall;
    end

    // ************************************************************
    // configuration state
    // ************************************************************
    logic [1:0] clock_src;
    logic [1:0] conv_trig_src;
    logic [1:0] out_trig_src;
    logic       conv_trig_fall;
    logic       out_trig_fall;
    logic [1:0] scan_src;
    logic [1:0] strobe_src;
    logic [1:0] update_src;
    logic [5:0] sync_master;
    logic       refused;
    logic       soft_conv;
    logic       soft_out;

    // ************************************************************
    // register bus slave
    // ************************************************************
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        wr_low;
    logic [31:0] rd_word;
    logic [31:0] status_word;
    logic [1:0]  wr_scan;
    logic [1:0]  wr_strobe;
    logic        wr_clash;

    assign awready  = ~aw_held & ~bvalid;
    assign wready   = ~w_held & ~bvalid;
    assign arready  = ~rvalid;
    assign do_write = aw_held & w_held & ~bvalid;
    assign wr_low   = do_write & w_strb[0];

    // aux zero cannot be both strobe and scan source: strobe keeps it
    assign wr_strobe = legal(w_data[daq_timing_pkg::strobe_src_lsb +: 2]);
    assign wr_clash  = (wr_strobe == daq_timing_pkg::src_aux)
                     & (legal(w_data[daq_timing_pkg::scan_src_lsb +: 2]) == daq_timing_pkg::src_aux);
    assign wr_scan   = wr_clash ? daq_timing_pkg::src_internal
                                : legal(w_data[daq_timing_pkg::scan_src_lsb +: 2]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= daq_timing_pkg::resp_okay;
        end else begin
            if (awvalid & awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid & wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= reg_mapped(aw_addr) ? daq_timing_pkg::resp_okay : daq_timing_pkg::resp_slverr;
            end else if (bvalid & bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_src      <= daq_timing_pkg::reset_src;
            conv_trig_src  <= daq_timing_pkg::reset_src;
            out_trig_src   <= daq_timing_pkg::reset_src;
            conv_trig_fall <= 1'b0;
            out_trig_fall  <= 1'b0;
            scan_src       <= daq_timing_pkg::reset_src;
            strobe_src     <= daq_timing_pkg::reset_src;
            update_src     <= daq_timing_pkg::reset_src;
            sync_master    <= daq_timing_pkg::reset_master;
        end else if (wr_low) begin
            if (aw_addr == daq_timing_pkg::clock_src_offset) begin
                clock_src <= legal(w_data[1:0]);
            end
            if (aw_addr == daq_timing_pkg::trigger_src_offset) begin
                conv_trig_src  <= w_data[daq_timing_pkg::conv_trig_src_lsb +: 2];
                out_trig_src   <= w_data[daq_timing_pkg::out_trig_src_lsb +: 2];
                conv_trig_fall <= w_data[daq_timing_pkg::conv_trig_fall_bit];
                out_trig_fall  <= w_data[daq_timing_pkg::out_trig_fall_bit];
            end
            if (aw_addr == daq_timing_pkg::strobe_src_offset) begin
                scan_src   <= wr_scan;
                strobe_src <= wr_strobe;
                update_src <= legal(w_data[daq_timing_pkg::update_src_lsb +: 2]);
            end
            if (aw_addr == daq_timing_pkg::sync_master_offset) begin
                sync_master <= w_data[5:0];
            end
        end
    end

    // software triggers are write pulses; the refused flag is sticky
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_conv <= 1'b0;
            soft_out  <= 1'b0;
            refused   <= 1'b0;
        end else begin
            soft_conv <= wr_low & (aw_addr == daq_timing_pkg::soft_trig_offset)
                       & w_data[daq_timing_pkg::soft_conv_bit];
            soft_out  <= wr_low & (aw_addr == daq_timing_pkg::soft_trig_offset)
                       & w_data[daq_timing_pkg::soft_out_bit];
            // set wins over a clear landing in the same cycle
            if (wr_low & (aw_addr == daq_timing_pkg::strobe_src_offset) & wr_clash) begin
                refused <= 1'b1;
            end else if (wr_low & (aw_addr == daq_timing_pkg::status_offset)
                         & w_data[daq_timing_pkg::refused_bit]) begin
                refused <= 1'b0;
            end
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic ext_strobe_mode;
    logic aux_zero_scan;

    assign status_word = {23'h000000, lvl[11:6], refused, aux_zero_scan, ext_strobe_mode};
    assign rd_word =
        (araddr == daq_timing_pkg::clock_src_offset)   ? {30'h0, clock_src} :
        (araddr == daq_timing_pkg::trigger_src_offset) ? {26'h0, out_trig_fall, conv_trig_fall,
                                                          out_trig_src, conv_trig_src} :
        (araddr == daq_timing_pkg::strobe_src_offset)  ? {26'h0, update_src, strobe_src, scan_src} :
        (araddr == daq_timing_pkg::sync_master_offset) ? {26'h0, sync_master} :
        (araddr == daq_timing_pkg::status_offset)      ? status_word : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= daq_timing_pkg::resp_okay;
        end else if (arvalid & arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= reg_mapped(araddr) ? daq_timing_pkg::resp_okay : daq_timing_pkg::resp_slverr;
        end else if (rvalid & rready) begin
            rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // source selection
    // ************************************************************
    logic       tick_sel;
    logic       clock_lvl;
    logic       conv_ext_edge;
    logic       out_ext_edge;
    logic       conv_trig_sel;
    logic       out_trig_sel;
    logic       aux_zero_at_tick;
    logic       aux_zero_scan_edge;
    logic       scan_req;
    logic       scan_pending;
    logic       next_scan_pending;
    logic       strobe_sel;
    logic       update_sel;
    logic [5:0] slave;

    // one tick feeds the count clock output and scan start alike
    assign tick_sel  = pick(clock_src, rise[daq_timing_pkg::in_int_clk],
                            rise[daq_timing_pkg::in_ext_clk],
                            rise[daq_timing_pkg::in_bus_base + daq_timing_pkg::bus_clock], 1'b0);
    assign clock_lvl = pick(clock_src, lvl[daq_timing_pkg::in_int_clk],
                            lvl[daq_timing_pkg::in_ext_clk],
                            lvl[daq_timing_pkg::in_bus_base + daq_timing_pkg::bus_clock], 1'b0);

    assign ext_strobe_mode = (strobe_src == daq_timing_pkg::src_aux);
    assign aux_zero_scan   = (scan_src == daq_timing_pkg::src_aux);

    assign conv_ext_edge = conv_trig_fall ? fall[daq_timing_pkg::in_conv_ext]
                                          : rise[daq_timing_pkg::in_conv_ext];
    assign out_ext_edge  = out_trig_fall ? fall[daq_timing_pkg::in_out_ext]
                                         : rise[daq_timing_pkg::in_out_ext];
    assign conv_trig_sel = pick(conv_trig_src, soft_conv, conv_ext_edge, analog_trigger,
                                rise[daq_timing_pkg::in_bus_base + daq_timing_pkg::bus_conv_trg]);
    assign out_trig_sel  = pick(out_trig_src, soft_out, out_ext_edge, analog_trigger,
                                rise[daq_timing_pkg::in_bus_base + daq_timing_pkg::bus_out_trg]);

    // aux zero as scan source is sampled on count ticks, so a pulse
    // shorter than one count period may be missed
    assign aux_zero_scan_edge = tick_sel & lvl[daq_timing_pkg::in_aux_zero] & ~aux_zero_at_tick;
    assign scan_req = pick(scan_src, scan_interval_tick, aux_zero_scan_edge,
                           rise[daq_timing_pkg::in_bus_base + daq_timing_pkg::bus_scan], 1'b0);
    assign next_scan_pending = ~ext_strobe_mode & (scan_pending | scan_req) & ~tick_sel;

    assign strobe_sel = pick(strobe_src, conversion_tick, rise[daq_timing_pkg::in_aux_zero],
                             rise[daq_timing_pkg::in_bus_base + daq_timing_pkg::bus_strobe], 1'b0);
    assign update_sel = pick(update_src, update_tick, rise[daq_timing_pkg::in_aux_one],
                             rise[daq_timing_pkg::in_bus_base + daq_timing_pkg::bus_update], 1'b0);

    assign slave = {update_src == daq_timing_pkg::src_bus,
                    out_trig_src == daq_timing_pkg::trig_src_bus,
                    strobe_src == daq_timing_pkg::src_bus,
                    scan_src == daq_timing_pkg::src_bus,
                    conv_trig_src == daq_timing_pkg::trig_src_bus,
                    clock_src == daq_timing_pkg::src_bus};

    // ************************************************************
    // routed outputs
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux_zero_at_tick     <= 1'b0;
            scan_pending         <= 1'b0;
            count_clock_tick     <= 1'b0;
            converter_trigger    <= 1'b0;
            output_path_trigger  <= 1'b0;
            scan_begin           <= 1'b0;
            conversion_strobe    <= 1'b0;
            output_update_strobe <= 1'b0;
        end else begin
            if (tick_sel) begin
                aux_zero_at_tick <= lvl[daq_timing_pkg::in_aux_zero];
            end
            scan_pending         <= next_scan_pending;
            count_clock_tick     <= tick_sel;
            converter_trigger    <= conv_trig_sel & ~ext_strobe_mode;
            output_path_trigger  <= out_trig_sel;
            scan_begin           <= ~ext_strobe_mode & tick_sel & (scan_pending | scan_req);
            conversion_strobe    <= strobe_sel;
            output_update_strobe <= update_sel;
        end
    end

    // a line taken from the bus is never driven back, which avoids a loop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            card_sync_bus_out  <= 6'h00;
            card_sync_bus_oe_n <= 6'h3f;
        end else begin
            card_sync_bus_out  <= {update_sel, out_trig_sel, strobe_sel,
                                   ~ext_strobe_mode & tick_sel & (scan_pending | scan_req),
                                   conv_trig_sel & ~ext_strobe_mode, clock_lvl};
            card_sync_bus_oe_n <= ~(sync_master & ~slave);
        end
    end

endmodule : daq_timing_signal_router

// [verification/router_monitor.sv]
// Purpose: port-level checks of the timing router
// Assumes: one clock aclk, synchronous reset aresetn
// Notes: sees only the top ports
`timescale 1ns/10ps
module router_monitor (
    input wire logic       aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic       arvalid, arready, rvalid, count_clock_tick, scan_begin,
    input wire logic [1:0] bresp,
    input wire logic [5:0] card_sync_bus_oe_n
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_reset_idle: assert property ($rose(aresetn) |-> card_sync_bus_oe_n == 6'h3f && !scan_begin)
        else $error("bus driven after reset");
    chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("no write response");
    chk_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("no read response");
    chk_busy_refuse: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    chk_read_refuse: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
    chk_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    chk_tick_single: assert property (count_clock_tick |=> !count_clock_tick)
        else $error("count tick too long");
    chk_scan_aligned: assert property (scan_begin |-> count_clock_tick)
        else $error("scan begin off tick");
endmodule : router_monitor
bind daq_timing_signal_router router_monitor i_router_monitor (.aclk, .aresetn, .awvalid, .awready, .wvalid,
    .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .count_clock_tick, .scan_begin, .bresp,
    .card_sync_bus_oe_n);

// [verification/ext_stim.sv]
// Purpose: external circuitry driving aux and trigger pins
// Assumes: pins are async to aclk
// Notes: pins 0 aux zero, 1 aux one, 2 and 3 converter and output triggers
`timescale 1ns/10ps
module ext_stim (
    input wire logic  aclk,
    output logic [3:0] pins
);
    initial pins = 4'h0;
    // twelve cycles per level keeps a scan pulse above two count periods
    task automatic level(input int idx, input logic v);
        pins[idx] <= v;
        repeat (12) @(posedge aclk);
    endtask : level
    task automatic burst(input int idx, input int n);
        repeat (n) begin
            level(idx, 1'b1);
            level(idx, 1'b0);
        end
    endtask : burst
endmodule : ext_stim

// [verification/daq_timing_signal_router_tb.sv]
// Purpose: self-checking bench for the timing router
// Assumes: 100 MHz aclk, 25 MHz count oscillator from the bench
// Notes: pulse counts are compared with counts expected from the pin stimulus
`timescale 1ns/10ps
module daq_timing_signal_router_tb;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, rd_word;
    logic [3:0] wstrb = 4'hf;
    logic scan_interval_tick = 1'b0, conversion_tick = 1'b0, update_tick = 1'b0, analog_trigger = 1'b0;
    logic internal_count_clock_in = 1'b0, external_count_clock_in = 1'b0;
    logic [5:0] card_sync_bus_in = 6'h0, card_sync_bus_out, card_sync_bus_oe_n;
    wire aux_input_zero, aux_input_one, converter_ext_trigger_in, output_ext_trigger_in;
    logic awready, wready, bvalid, arready, rvalid, count_clock_tick, converter_trigger, output_path_trigger;
    logic scan_begin, conversion_strobe, output_update_strobe;
    logic [1:0] bresp, rresp, rd_resp;
    int fails = 0, checks = 0, cyc = 0, seed = 32'h5d94, n, b_conv, b_trig, b_upd, b_out;
    int n_conv = 0, n_trig = 0, n_upd = 0, n_out = 0, n_tick = 0, b_tick;
    daq_timing_signal_router i_daq_timing_signal_router (.*);
    ext_stim i_ext_stim (.aclk, .pins({output_ext_trigger_in, converter_ext_trigger_in, aux_input_one, aux_input_zero}));
    always #5 aclk = ~aclk;
    always #20 internal_count_clock_in = ~internal_count_clock_in;
    always #40 external_count_clock_in = ~external_count_clock_in; // 12.5 MHz, inside the allowed band
    always #30 card_sync_bus_in[0] = ~card_sync_bus_in[0];
    // random internal ticks must be ignored whenever an aux pin owns the signal
    always @(posedge aclk) begin
        {scan_interval_tick, conversion_tick, update_tick} <= 3'($random(seed));
        n_conv <= n_conv + int'(conversion_strobe);
        n_trig <= n_trig + int'(converter_trigger);
        n_upd <= n_upd + int'(output_update_strobe);
        n_out <= n_out + int'(output_path_trigger);
        n_tick <= n_tick + int'(count_clock_tick);
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b0;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0; wvalid <= 1'b0;
        repeat (2) @(posedge aclk);
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd_word = rdata; rd_resp = rresp;
    endtask : rd
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(daq_timing_pkg::strobe_src_offset); cmp(rd_word, 32'h0);
        rd(8'h40); cmp({rd_resp, rd_word[29:0]}, {daq_timing_pkg::resp_slverr, 30'h0});
        n = {$random(seed)} % 4 + 1;
        // scan and strobe both ask for aux zero: only the strobe may keep it
        wr(daq_timing_pkg::strobe_src_offset, 32'h15);
        rd(daq_timing_pkg::strobe_src_offset); cmp(rd_word, 32'h14);
        rd(daq_timing_pkg::status_offset); cmp(rd_word & 32'h7, 32'h5);
        b_conv = n_conv; b_trig = n_trig; b_upd = n_upd;
        wr(daq_timing_pkg::soft_trig_offset, 32'h1);
        i_ext_stim.burst(0, n);
        i_ext_stim.burst(1, n + 1);
        cmp(32'(n_conv - b_conv), 32'(n));
        cmp(32'(n_trig - b_trig), 32'h0);
        cmp(32'(n_upd - b_upd), 32'(n + 1));
        wr(daq_timing_pkg::strobe_src_offset, 32'h0);
        wr(daq_timing_pkg::trigger_src_offset, 32'h11);
        b_trig = n_trig; b_out = n_out;
        i_ext_stim.level(2, 1'b1); cmp(32'(n_trig - b_trig), 32'h0);
        i_ext_stim.level(2, 1'b0); cmp(32'(n_trig - b_trig), 32'h1);
        wr(daq_timing_pkg::soft_trig_offset, 32'h2);
        repeat (6) @(posedge aclk);
        cmp(32'(n_out - b_out), 32'h1);
        b_tick = n_tick; repeat (120) @(posedge aclk); cmp(32'(n_tick - b_tick), 32'h1e);
        wr(daq_timing_pkg::clock_src_offset, 32'h1);
        b_tick = n_tick; repeat (120) @(posedge aclk); cmp(32'(n_tick - b_tick), 32'hf);
        wr(daq_timing_pkg::sync_master_offset, 32'h3f); cmp(32'(card_sync_bus_oe_n), 32'h0);
        wr(daq_timing_pkg::clock_src_offset, 32'h2); cmp(32'(card_sync_bus_oe_n), 32'h1);
        b_tick = n_tick; repeat (120) @(posedge aclk); cmp(32'(n_tick - b_tick), 32'h14);
        conclude();
    end
endmodule : daq_timing_signal_router_tb
